/* File: common/adc_pair_params.svh */
// offsets, field positions, reset values and trigger codes of the pair block
`ifndef ADC_PAIR_PARAMS_SVH
`define ADC_PAIR_PARAMS_SVH

`define PAIR_CTRL_OFFSET 12'h000
`define CONV_CTRL_OFFSET 12'h004
`define RESULT_BASE_OFFSET 12'h040
`define RESULT_COUNT 12
`define RESULT_BITS 10
`define WORD_BITS 16

`define CTRL_SEL_LSB 0
`define CTRL_SEL_MSB 4
`define CTRL_SOFT_BIT 5
`define CTRL_PEND_BIT 6
`define CTRL_IRQEN_BIT 7
`define CONV_ORDER_BIT 0
`define CTRL_RESET 8'h00

`define TRG_NONE 5'h00
`define TRG_SOFT 5'h01
`define TRG_GLOBAL 5'h02
`define TRG_SPECIAL 5'h03
`define TRG_GEN_FIRST 5'h04
`define TRG_GEN_LAST 5'h07
`define TRG_TMR1 5'h0C
`define TRG_TMR2 5'h0D
`define TRG_CL_FIRST 5'h0E
`define TRG_CL_LAST 5'h11
`define TRG_FLT_FIRST 5'h16
`define TRG_FLT_LAST 5'h19

`define CHAN_EVEN 4'h8
`define CHAN_ODD 4'h9

`endif

/* File: common/adc_pair_pkg.sv */
// types shared by the pair trigger and result buffer block
package adc_pair_pkg;
    typedef struct packed {
        logic global_sw;
        logic special_event;
        logic [3:0] gen;
        logic [3:0] current_limit;
        logic [3:0] fault;
        logic timer1_match;
        logic timer2_match;
    } trigger_in_t;

    typedef struct packed {
        logic done;
        logic [3:0] channel;
        logic [9:0] data;
    } sar_result_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT1 = 5'b00010,
        ST_CONV1 = 5'b00100,
        ST_WAIT2 = 5'b01000,
        ST_CONV2 = 5'b10000
    } pair_state_t;
endpackage

/* File: hdl/result_mem.sv */
// per-input result storage with registered read data
`timescale 1ns/1ps
`default_nettype none
`include "adc_pair_params.svh"
module result_mem (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [9:0] wdata,
    input wire logic [3:0] raddr,
    output logic [9:0] rdata
);
    logic [9:0] mem_r [0:`RESULT_COUNT-1];

    genvar gi;
    generate
        for (gi = 0; gi < `RESULT_COUNT; gi = gi + 1) begin : g_entry
            always_ff @(posedge core_clk or posedge rst) begin
                if (rst) begin
                    mem_r[gi] <= 10'h000;
                end else if (we && waddr == 4'(gi)) begin
                    mem_r[gi] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= 10'h000;
        end else if (raddr < 4'(`RESULT_COUNT)) begin
            rdata <= mem_r[raddr];
        end else begin
            rdata <= 10'h000;
        end
    end
endmodule
`default_nettype wire

/* File: hdl/adc_pair_trigger_result_buffer.sv */
// trigger selection, conversion sequencing and result buffer for the 8/9 pair
`timescale 1ns/1ps
`default_nettype none
`include "adc_pair_params.svh"
// Notes on behaviour
// - low five control bits pick the pair trigger; zero disables the pair
// - code 1 own soft trigger, 2 global soft trigger, 3 special event
// - codes 4 to 7 pick generator triggers one to four
// - code 12 timer one period match, code 13 timer two
// - codes 14 to 17 pick current-limit triggers of generators one to four
// - codes 22 to 25 pick fault triggers of generators one to four
// - twelve result registers, each result lands in its input's register
// - no ring or FIFO; location depends only on input number
// - ten-bit results are read back as sixteen-bit words
// - bus writes never change result registers
// - results are written on the core clock
// - an unread result is overwritten by the next one for that input
// - after the done event a read returns the finished value
// - sample at trigger time even while the converter is busy
// - order bit zero converts input eight then nine
// - order bit one converts input nine then eight
// - soft trigger bit requests the pair, waits, self-clears on pending
// - pending sets on trigger, clears when both inputs are converted
module adc_pair_trigger_result_buffer (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire adc_pair_pkg::trigger_in_t trig_in,
    input wire logic sar_busy,
    input wire adc_pair_pkg::sar_result_t sar_res,
    output logic sample_strobe,
    output logic sar_start,
    output logic [3:0] sar_channel,
    output logic pair_done
);
    import adc_pair_pkg::*;

    logic [7:0] ctrl_r;
    logic order_r;
    logic order_lat_r;
    logic pend_r;
    pair_state_t state_r;
    logic [3:0] chan_r;
    logic start_r;
    logic sample_r;
    logic done_r;
    logic hready_r;
    logic [31:0] hrdata_r;
    logic dphase_r;
    logic dwrite_r;
    logic [11:0] daddr_r;
    logic [9:0] mem_rdata;
    pair_state_t state_nxt;

    // bus decode; hsize is ignored since only whole words are used
    wire accept = hsel && htrans[1] && hready;
    wire [3:0] res_idx = daddr_r[5:2];
    wire hit_ctrl = daddr_r == `PAIR_CTRL_OFFSET;
    wire hit_conv = daddr_r == `CONV_CTRL_OFFSET;
    wire hit_res = daddr_r[11:6] == `RESULT_BASE_OFFSET >> 6 && res_idx < 4'(`RESULT_COUNT);
    wire last_dcyc = dphase_r && !hready_r;
    wire ctrl_wr = last_dcyc && dwrite_r && hit_ctrl;
    wire conv_wr = last_dcyc && dwrite_r && hit_conv;
    wire [3:0] mem_raddr = haddr[5:2];
    wire unused_ok = ^hsize;

    wire [4:0] sel_code = ctrl_r[`CTRL_SEL_MSB:`CTRL_SEL_LSB];
    wire [4:0] cl_off = sel_code - `TRG_CL_FIRST;
    wire [4:0] flt_off = sel_code - `TRG_FLT_FIRST;
    // one trigger per generator from the outside unit
    wire gen_hit = sel_code >= `TRG_GEN_FIRST && sel_code <= `TRG_GEN_LAST;
    wire cl_hit = sel_code >= `TRG_CL_FIRST && sel_code <= `TRG_CL_LAST;
    wire flt_hit = sel_code >= `TRG_FLT_FIRST && sel_code <= `TRG_FLT_LAST;
    wire trg_fixed = (sel_code == `TRG_SOFT && ctrl_r[`CTRL_SOFT_BIT])
        || (sel_code == `TRG_GLOBAL && trig_in.global_sw)
        || (sel_code == `TRG_SPECIAL && trig_in.special_event);
    wire trg_gen = gen_hit && trig_in.gen[sel_code[1:0]];
    wire trg_tmr = (sel_code == `TRG_TMR1 && trig_in.timer1_match)
        || (sel_code == `TRG_TMR2 && trig_in.timer2_match);
    wire trg_cl = cl_hit && trig_in.current_limit[cl_off[1:0]];
    wire trg_flt = flt_hit && trig_in.fault[flt_off[1:0]];
    // any other code, zero included, yields no trigger
    wire trig_fire = trg_fixed || trg_gen || trg_tmr || trg_cl || trg_flt;

    wire conv_ok = sar_res.done && sar_res.channel == chan_r;
    wire last_conv = state_r == ST_CONV2 && conv_ok;
    // even input first when order is zero
    wire [3:0] first_chan = order_r ? `CHAN_ODD : `CHAN_EVEN;
    // odd input second when order is zero, first when it is one
    wire [3:0] second_chan = order_lat_r ? `CHAN_EVEN : `CHAN_ODD;

    // ten bits zero-extended into the sixteen-bit word
    wire [31:0] res_word = {16'h0000, 6'h00, mem_rdata};
    wire [31:0] ctrl_word = {24'h000000, ctrl_r[`CTRL_IRQEN_BIT], pend_r, ctrl_r[`CTRL_SOFT_BIT:0]};
    // read path shows stored finished value
    wire [31:0] rd_word = hit_res ? res_word : hit_ctrl ? ctrl_word :
        hit_conv ? {31'h00000000, order_r} : 32'h00000000;

    // result written to its own input register
    // address is the input number, no ring pointer
    result_mem u_mem (
        .core_clk(core_clk),
        .rst(rst),
        .we(sar_res.done),
        .waddr(sar_res.channel),
        .wdata(sar_res.data),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // every transfer gets one wait cycle so the memory read can settle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hready_r <= 1'b1;
            dphase_r <= 1'b0;
            dwrite_r <= 1'b0;
            daddr_r <= 12'h000;
            hrdata_r <= 32'h00000000;
        end else if (accept) begin
            hready_r <= 1'b0;
            dphase_r <= 1'b1;
            dwrite_r <= hwrite;
            daddr_r <= {haddr[11:2], 2'b00};
        end else if (last_dcyc) begin
            hready_r <= 1'b1;
            dphase_r <= 1'b0;
            hrdata_r <= dwrite_r ? 32'h00000000 : rd_word;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= `CTRL_RESET;
            order_r <= 1'b0;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= {hwdata[`CTRL_IRQEN_BIT], 1'b0, hwdata[`CTRL_SOFT_BIT:0]};
            end else if (trig_fire) begin
                // soft bit self-clears when pending sets
                ctrl_r[`CTRL_SOFT_BIT] <= 1'b0;
            end
            if (conv_wr) begin
                order_r <= hwdata[`CONV_ORDER_BIT];
            end
        end
    end

    // trigger sets pending and wins over the completion clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pend_r <= 1'b0;
        end else if (trig_fire) begin
            pend_r <= 1'b1;
        end else if (last_conv) begin
            pend_r <= 1'b0;
        end
    end

    // pending request waits while converter resources are busy
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (pend_r) state_nxt = ST_WAIT1;
            ST_WAIT1: if (!sar_busy) state_nxt = ST_CONV1;
            ST_CONV1: if (conv_ok) state_nxt = ST_WAIT2;
            ST_WAIT2: if (!sar_busy) state_nxt = ST_CONV2;
            ST_CONV2: if (conv_ok) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            chan_r <= `CHAN_EVEN;
            order_lat_r <= 1'b0;
            start_r <= 1'b0;
            done_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            start_r <= (state_r == ST_WAIT1 || state_r == ST_WAIT2) && !sar_busy;
            done_r <= last_conv;
            // order taken once per pair so a mid-pair write cannot split it
            if (state_r == ST_IDLE && pend_r) begin
                order_lat_r <= order_r;
                chan_r <= first_chan;
            end else if (state_r == ST_WAIT2 && !sar_busy) begin
                chan_r <= second_chan;
            end
        end
    end

    // sample strobe follows the trigger regardless of busy
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sample_r <= 1'b0;
        end else begin
            sample_r <= trig_fire;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0 & unused_ok;
        end
    end

    assign hreadyout = hready_r;
    assign hrdata = hrdata_r;
    assign sample_strobe = sample_r;
    assign sar_start = start_r;
    assign sar_channel = chan_r;
    assign pair_done = done_r;

    chk_sample_at_trigger: assert property (@(posedge core_clk) disable iff (rst)
        trig_fire |=> sample_r && pend_r) else $error("trigger not sampled");
    chk_disabled_stays_idle: assert property (@(posedge core_clk) disable iff (rst)
        (sel_code == `TRG_NONE && !pend_r && !ctrl_wr) |=> !pend_r) else $error("disabled pair became pending");
    chk_unassigned_code: assert property (@(posedge core_clk) disable iff (rst)
        (sel_code >= 5'h08 && sel_code <= 5'h0B && !pend_r) |=> !pend_r) else $error("unassigned code fired");
    chk_first_order: assert property (@(posedge core_clk) disable iff (rst)
        (state_r == ST_CONV1) |-> sar_channel == (order_lat_r ? `CHAN_ODD : `CHAN_EVEN))
        else $error("first channel wrong");
    chk_second_order: assert property (@(posedge core_clk) disable iff (rst)
        (state_r == ST_CONV2) |-> sar_channel == (order_lat_r ? `CHAN_EVEN : `CHAN_ODD))
        else $error("second channel wrong");
    chk_pend_clears: assert property (@(posedge core_clk) disable iff (rst)
        (last_conv && !trig_fire) |=> !pend_r ##0 pair_done) else $error("pending not cleared");
    chk_soft_selfclear: assert property (@(posedge core_clk) disable iff (rst)
        (trig_fire && !ctrl_wr) |=> !ctrl_r[`CTRL_SOFT_BIT]) else $error("soft trigger stuck");
    chk_one_wait_state: assert property (@(posedge core_clk) disable iff (rst)
        accept |=> !hreadyout ##1 hreadyout) else $error("bus answer timing wrong");
    chk_result_format: assert property (@(posedge core_clk) disable iff (rst)
        ($rose(hreadyout) && !dwrite_r && hit_res) |-> hrdata[31:10] == 22'h000000)
        else $error("result upper bits not zero");
endmodule
`default_nettype wire

/* File: sim/sar_model.sv */
// converter model that answers start requests and injects stray results
`timescale 1ns/1ps
`default_nettype none
module sar_model
    import adc_pair_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic sar_start,
    input wire logic [3:0] sar_channel,
    input wire logic stall,
    input wire logic inj,
    input wire logic [3:0] inj_ch,
    input wire logic [9:0] inj_data,
    output logic sar_busy,
    output adc_pair_pkg::sar_result_t sar_res
);
    logic [2:0] cnt_r;
    logic [3:0] ch_r;
    // stall stands in for other pairs holding the converter
    assign sar_busy = stall | (cnt_r != 3'h0);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt_r <= 3'h0;
            ch_r <= 4'h0;
            sar_res <= '0;
        end else begin
            // idle fields toggle so stale values never look valid
            sar_res.done <= 1'h0;
            sar_res.channel <= ~sar_res.channel;
            sar_res.data <= ~sar_res.data;
            if (sar_start) begin
                cnt_r <= 3'h4;
                ch_r <= sar_channel;
            end else if (cnt_r != 3'h0) begin
                cnt_r <= cnt_r - 3'h1;
                if (cnt_r == 3'h1)
                    sar_res <= {1'h1, ch_r, ch_r, 6'h15};
            end else if (inj) begin
                sar_res <= {1'h1, inj_ch, inj_data};
            end
        end
    end
endmodule
`default_nettype wire

/* File: sim/adc_pair_trigger_result_buffer_tb.sv */
// self-checking bench for the pair trigger and result buffer block
`timescale 1ns/1ps
`default_nettype none
module adc_pair_trigger_result_buffer_tb;
    import adc_pair_pkg::*;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic hsel = 1'h0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'h0;
    logic [31:0] hwdata = 32'h0;
    trigger_in_t trig_in = '0;
    logic stall = 1'h0;
    logic inj = 1'h0;
    logic [3:0] inj_ch = 4'h0;
    logic [9:0] inj_data = 10'h000;
    logic hreadyout, hresp, sample_strobe, sar_start, pair_done, sar_busy;
    logic [31:0] hrdata;
    logic [3:0] sar_channel;
    sar_result_t sar_res;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    logic [3:0] log_q [$];
    always #12.5 core_clk = ~core_clk;
    adc_pair_trigger_result_buffer dut (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .trig_in(trig_in), .sar_busy(sar_busy),
        .sar_res(sar_res), .sample_strobe(sample_strobe), .sar_start(sar_start),
        .sar_channel(sar_channel), .pair_done(pair_done));
    sar_model far (.core_clk(core_clk), .rst(rst), .sar_start(sar_start), .sar_channel(sar_channel),
        .stall(stall), .inj(inj), .inj_ch(inj_ch), .inj_data(inj_data), .sar_busy(sar_busy),
        .sar_res(sar_res));
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge core_clk) begin
        cyc++;
        // long enough for every test with a wide margin
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        // no assumed latency; only the cycle ceiling ends a stuck wait
        do begin
            @(posedge core_clk);
        end while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge core_clk);
        end while (hreadyout !== 1'h1);
        r = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'h1, a, d, r);
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'h0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic pulse(input logic [15:0] v, output logic s);
        trig_in <= v;
        @(posedge core_clk);
        trig_in <= '0;
        @(posedge core_clk);
        s = sample_strobe;
    endtask
    task automatic wait_pair();
        int n;
        n = 0;
        log_q = {};
        while (pair_done !== 1'h1 && n < 80) begin
            @(posedge core_clk);
            n++;
            if (sar_start === 1'h1)
                log_q.push_back(sar_channel);
        end
        chk(n < 80, 1'h1);
        chk(log_q.size(), 2);
    endtask
    // source struct is sixteen bits: global, special, gen 4, current-limit 4, fault 4, timer1, timer2
    function automatic logic [15:0] trig_of(input int c);
        if (c == 2) return 16'h8000;
        if (c == 3) return 16'h4000;
        if (c >= 4 && c <= 7) return 16'h0400 << (c - 4);
        if (c == 12) return 16'h0002;
        if (c == 13) return 16'h0001;
        if (c >= 14 && c <= 17) return 16'h0040 << (c - 14);
        if (c >= 22 && c <= 25) return 16'h0004 << (c - 22);
        return 16'h0000;
    endfunction
    task automatic test_codes();
        logic s;
        logic [15:0] v;
        for (int c = 0; c < 32; c++) begin
            v = trig_of(c);
            wr(12'h004, c & 1);
            wr(12'h000, c);
            if (v != 0) begin
                // every other source pulses; only the selected one may start the pair
                pulse(~v, s);
                chk(s, 1'h0);
            end
            // external sources pulse; unassigned codes see every source at once
            pulse((v != 0) ? v : 16'hFFFF, s);
            chk(s, v != 0);
            if (v != 0) begin
                wait_pair();
                chk(log_q[0], (c & 1) ? 4'h9 : 4'h8);
                chk(log_q[1], (c & 1) ? 4'h8 : 4'h9);
                rd_chk(12'h000, c);
                rd_chk(12'h060, {22'h0, 4'h8, 6'h15});
                rd_chk(12'h064, {22'h0, 4'h9, 6'h15});
            end
        end
        $display("test trigger codes done");
    endtask
    task automatic test_busy_soft();
        logic s;
        int k;
        k = 0;
        stall <= 1'h1;
        wr(12'h000, 32'h4);
        pulse(16'h0400, s);
        chk(s, 1'h1);
        repeat (10) begin
            @(posedge core_clk);
            k += (sar_start === 1'h1);
        end
        chk(k, 0);
        rd_chk(12'h000, 32'h44);
        stall <= 1'h0;
        wait_pair();
        stall <= 1'h1;
        wr(12'h000, 32'h21);
        rd_chk(12'h000, 32'h41);
        stall <= 1'h0;
        wait_pair();
        rd_chk(12'h000, 32'h01);
        wr(12'h000, 32'h20);
        rd_chk(12'h000, 32'h20);
        $display("test busy and soft trigger done");
    endtask
    task automatic inject(input logic [3:0] ch, input logic [9:0] d);
        inj <= 1'h1;
        inj_ch <= ch;
        inj_data <= d;
        @(posedge core_clk);
        inj <= 1'h0;
        repeat (2) @(posedge core_clk);
    endtask
    task automatic test_results();
        for (int i = 11; i >= 0; i--)
            inject(i[3:0], {6'h2A, i[3:0]});
        for (int i = 0; i < 12; i++)
            rd_chk(12'h040 + 4 * i, {22'h0, 6'h2A, i[3:0]});
        inject(4'h3, 10'h1C3);
        inject(4'h3, 10'h2B4);
        rd_chk(12'h04C, 32'h2B4);
        wr(12'h04C, 32'hFFFFFFFF);
        rd_chk(12'h04C, 32'h2B4);
        rd_chk(12'h100, 32'h0);
        $display("test result buffer done");
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        rst <= 1'h0;
        @(posedge core_clk);
        chk(sar_channel, 4'h8);
        chk(hresp, 1'h0);
        rd_chk(12'h000, 32'h0);
        rd_chk(12'h004, 32'h0);
        rd_chk(12'h040, 32'h0);
        $display("test reset done");
        test_codes();
        test_busy_soft();
        test_results();
        print_verdict();
    end
endmodule
`default_nettype wire
